/* sw_global_regs.sv */
// Register bank for host-port egress rate, global controls and source filters
`timescale 1ns/1ps
`default_nettype none
module sw_global_regs #(
	parameter int FLUSH_LEN = sw_regs_pkg::FLUSH_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Host register port, 16-bit word access
	input wire logic [11:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [1:0] BE,
	input wire logic [15:0] WDATA,
	output logic [15:0] RDATA,
	// Settings to the switch core
	output sw_regs_pkg::egress_cfg_s EGRESS_CFG,
	output sw_regs_pkg::global_cfg_s GLOBAL_CFG,
	output logic [47:0] SRC_FILTER1,
	output logic [47:0] SRC_FILTER2,
	output logic DYN_FLUSH_REQ
);
	////////////////////////////////////////////////////////////////////
	logic rst_s1_q;
	logic rst_b_q;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_s1_q <= 1'b0;
			rst_b_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_b_q <= rst_s1_q;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Storage: index 0 lo-egress, 1 hi-egress, 2 ctl A, 3 ctl B, 4..9 filters
	logic [15:0] regs_q [10];
	logic [15:0] wmask;
	logic [3:0] idx;
	logic hit;
	logic [15:0] flush_cnt_q;
	always_comb begin
		wmask = {{8{BE[1]}}, {8{BE[0]}}};
		hit = 1'b1;
		idx = 4'h0;
		if (ADDR == sw_regs_pkg::OFF_EGR_LO) begin
			idx = 4'h0;
		end else if (ADDR == sw_regs_pkg::OFF_EGR_HI) begin
			idx = 4'h1;
		end else if (ADDR == sw_regs_pkg::OFF_GCA) begin
			idx = 4'h2;
		end else if (ADDR == sw_regs_pkg::OFF_GCB) begin
			idx = 4'h3;
		end else if (ADDR == sw_regs_pkg::OFF_SF1_LO) begin
			idx = 4'h4;
		end else if (ADDR == sw_regs_pkg::OFF_SF1_MID) begin
			idx = 4'h5;
		end else if (ADDR == sw_regs_pkg::OFF_SF1_HI) begin
			idx = 4'h6;
		end else if (ADDR == sw_regs_pkg::OFF_SF2_LO) begin
			idx = 4'h7;
		end else if (ADDR == sw_regs_pkg::OFF_SF2_MID) begin
			idx = 4'h8;
		end else if (ADDR == sw_regs_pkg::OFF_SF2_HI) begin
			idx = 4'h9;
		end else begin
			hit = 1'b0;
		end
	end
	function automatic logic [15:0] field_mask(input logic [3:0] i);
		case (i)
			4'h0: field_mask = sw_regs_pkg::MASK_EGR_LO;
			4'h1: field_mask = sw_regs_pkg::MASK_EGR_HI;
			4'h2: field_mask = sw_regs_pkg::MASK_GCA;
			4'h3: field_mask = sw_regs_pkg::MASK_GCB;
			default: field_mask = 16'hFFFF;
		endcase
	endfunction : field_mask
	////////////////////////////////////////////////////////////////////
	// Reserved bits are masked on write so they always read zero
	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_reg
			logic [15:0] m;
			logic [15:0] keep;
			assign m = wmask & field_mask(4'(g));
			// A write that leaves the flush bit alone must not swallow its self-clear
			assign keep = (g == 2 && flush_cnt_q == 16'h0001) ?
				~(16'h0001 << sw_regs_pkg::BIT_DYN_FLUSH) : 16'hFFFF;
			always_ff @(posedge CLK or negedge rst_b_q) begin
				if (!rst_b_q) begin
					regs_q[g] <= (g == 2) ? sw_regs_pkg::RST_GCA : sw_regs_pkg::RST_ZERO;
				end else if (WR && hit && idx == 4'(g)) begin
					regs_q[g] <= ((regs_q[g] & keep) & ~m) | (WDATA & m);
				end else if (g == 2 && flush_cnt_q == 16'h0001) begin
					regs_q[g][sw_regs_pkg::BIT_DYN_FLUSH] <= 1'b0;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// Flush runs for a fixed time then clears the request bit
	always_ff @(posedge CLK or negedge rst_b_q) begin
		if (!rst_b_q) begin
			flush_cnt_q <= 16'h0000;
		end else if (flush_cnt_q != 16'h0000) begin
			flush_cnt_q <= flush_cnt_q - 16'h0001;
		end else if (regs_q[2][sw_regs_pkg::BIT_DYN_FLUSH]) begin
			flush_cnt_q <= 16'(FLUSH_LEN);
		end
	end
	////////////////////////////////////////////////////////////////////
	// Outputs registered; rate codes forced to zero (full rate) when disabled
	always_ff @(posedge CLK or negedge rst_b_q) begin
		if (!rst_b_q) begin
			RDATA <= 16'h0000;
			EGRESS_CFG <= '0;
			GLOBAL_CFG <= '0;
			SRC_FILTER1 <= 48'h000000000000;
			SRC_FILTER2 <= 48'h000000000000;
			DYN_FLUSH_REQ <= 1'b0;
		end else begin
			RDATA <= (RD && hit) ? regs_q[idx] : 16'h0000;
			EGRESS_CFG.egress_en <= regs_q[0][sw_regs_pkg::BIT_EGR_EN];
			EGRESS_CFG.prio3_rate <= regs_q[0][7] ? regs_q[1][14:8] : 7'h00;
			EGRESS_CFG.prio2_rate <= regs_q[0][7] ? regs_q[1][6:0] : 7'h00;
			EGRESS_CFG.prio1_rate <= regs_q[0][7] ? regs_q[0][14:8] : 7'h00;
			EGRESS_CFG.prio0_rate <= regs_q[0][7] ? regs_q[0][6:0] : 7'h00;
			GLOBAL_CFG.two_queue_map <= regs_q[2][15:14];
			GLOBAL_CFG.static_flush_en <= regs_q[2][9];
			GLOBAL_CFG.tail_tag_en <= regs_q[2][8];
			GLOBAL_CFG.pause_limit <= regs_q[2][7:0];
			GLOBAL_CFG.pause_limit_en <= regs_q[2][7:0] != 8'h00;
			GLOBAL_CFG.invalid_vid_mask <= regs_q[3][10:8];
			GLOBAL_CFG.pvid_insert <= regs_q[3][5:0];
			SRC_FILTER1 <= {regs_q[6], regs_q[5], regs_q[4]};
			SRC_FILTER2 <= {regs_q[9], regs_q[8], regs_q[7]};
			DYN_FLUSH_REQ <= regs_q[2][sw_regs_pkg::BIT_DYN_FLUSH];
		end
	end
endmodule : sw_global_regs
`default_nettype wire

/* sw_regs_pkg.sv */
// Constants and types for the switch global control and source filter register bank
`default_nettype none
package sw_regs_pkg;
	localparam logic [11:0] OFF_EGR_LO = 12'h0A8;
	localparam logic [11:0] OFF_EGR_HI = 12'h0AA;
	localparam logic [11:0] OFF_GCA = 12'h0AC;
	localparam logic [11:0] OFF_GCB = 12'h0AE;
	localparam logic [11:0] OFF_SF1_LO = 12'h0B0;
	localparam logic [11:0] OFF_SF1_MID = 12'h0B2;
	localparam logic [11:0] OFF_SF1_HI = 12'h0B4;
	localparam logic [11:0] OFF_SF2_LO = 12'h0B6;
	localparam logic [11:0] OFF_SF2_MID = 12'h0B8;
	localparam logic [11:0] OFF_SF2_HI = 12'h0BA;
	localparam logic [15:0] MASK_EGR_HI = 16'h7F7F;
	localparam logic [15:0] MASK_EGR_LO = 16'h7FFF;
	localparam logic [15:0] MASK_GCA = 16'hC7FF;
	localparam logic [15:0] MASK_GCB = 16'h073F;
	localparam logic [15:0] RST_GCA = 16'h8000;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam int BIT_EGR_EN = 7;
	localparam int BIT_DYN_FLUSH = 10;
	localparam int PAUSE_UNIT_MS = 160;
	localparam int CLK_HZ = 40000000;
	localparam int FLUSH_CYCLES = 16;
	typedef struct packed {
		logic [6:0] prio3_rate;
		logic [6:0] prio2_rate;
		logic [6:0] prio1_rate;
		logic [6:0] prio0_rate;
		logic egress_en;
	} egress_cfg_s;
	typedef struct packed {
		logic [1:0] two_queue_map;
		logic static_flush_en;
		logic tail_tag_en;
		logic [7:0] pause_limit;
		logic pause_limit_en;
		logic [2:0] invalid_vid_mask;
		logic [5:0] pvid_insert;
	} global_cfg_s;
endpackage : sw_regs_pkg
`default_nettype wire

/* sw_global_regs_assertions.sv */
// Checker for the switch global register bank
`timescale 1ns/1ps
`default_nettype none
module sw_global_regs_assertions #(
	parameter int FLUSH_LEN = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Host port
	input wire logic [11:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [1:0] BE,
	input wire logic [15:0] WDATA,
	input wire logic [15:0] RDATA,
	// Settings
	input wire sw_regs_pkg::egress_cfg_s EGRESS_CFG,
	input wire sw_regs_pkg::global_cfg_s GLOBAL_CFG,
	input wire logic [47:0] SRC_FILTER1,
	input wire logic [47:0] SRC_FILTER2,
	input wire logic DYN_FLUSH_REQ
);
	localparam int FL_MIN = FLUSH_LEN;
	localparam int FL_MAX = FLUSH_LEN + 1;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	AST_EGR_OFF: assert property (!EGRESS_CFG.egress_en |-> EGRESS_CFG.prio3_rate == 7'h00)
		else $error("rate code out while limiting off");
	AST_PAUSE: assert property (GLOBAL_CFG.pause_limit_en == (GLOBAL_CFG.pause_limit != 8'h00))
		else $error("pause limit enable wrong");
	AST_RD_IDLE: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data without read");
	AST_RSV: assert property (RD && ADDR >= 12'h0BC |=> RDATA == 16'h0000)
		else $error("reserved range reads nonzero");
	// Request stands FLUSH_LEN plus one cycles, then drops
	AST_FL_LEN: assert property ($rose(DYN_FLUSH_REQ) |-> ##[FL_MAX:FL_MAX] !DYN_FLUSH_REQ)
		else $error("flush never ends");
	AST_FL_HOLD: assert property ($rose(DYN_FLUSH_REQ) |-> ##[FL_MIN:FL_MIN] DYN_FLUSH_REQ)
		else $error("flush ended early");
	AST_FL_CAUSE: assert property ($rose(DYN_FLUSH_REQ) |-> $past(WR, 2) && $past(WDATA[10], 2))
		else $error("flush without write");
	AST_PVID: assert property (WR && ADDR == 12'h0AE && BE == 2'h3 |=>
		##1 GLOBAL_CFG.pvid_insert == $past(WDATA[5:0], 2)) else $error("insert mask wrong");
	AST_TQ: assert property (WR && ADDR == 12'h0AC && BE[1] |=>
		##1 GLOBAL_CFG.two_queue_map == $past(WDATA[15:14], 2)) else $error("queue map wrong");
endmodule : sw_global_regs_assertions
bind sw_global_regs sw_global_regs_assertions #(.FLUSH_LEN(FLUSH_LEN)) u_chk (.*);
`default_nettype wire

/* sw_global_regs_tb.sv */
// Self-checking bench for the switch global register bank
`timescale 1ns/1ps
`default_nettype none
module sw_global_regs_tb;
	logic CLK = 0, RST_B = 0, WR = 0, RD = 0, DYN_FLUSH_REQ;
	logic [11:0] ADDR = 12'h000;
	logic [1:0] BE = 2'h3;
	logic [15:0] WDATA = 16'h0000, RDATA;
	sw_regs_pkg::egress_cfg_s EGRESS_CFG;
	sw_regs_pkg::global_cfg_s GLOBAL_CFG;
	logic [47:0] SRC_FILTER1, SRC_FILTER2;
	int errors = 0, tests_run = 0, cyc = 0;
	// Short flush keeps the run brief
	sw_global_regs #(.FLUSH_LEN(4)) DUT (.*);
	initial forever #12.5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			results();
		end
	end
	task results;
		$display("tests %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task chk(input logic [47:0] g, e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] b = 2'h3);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		BE <= b;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk(RDATA, e);
	endtask : rd
	task settle;
		repeat (2) @(posedge CLK);
		#1;
	endtask : settle
	task automatic wt(input logic v);
		int n = 0;
		while (DYN_FLUSH_REQ !== v && n < 40) begin
			@(posedge CLK);
			#1;
			n++;
		end
		chk(DYN_FLUSH_REQ, v);
	endtask : wt
	task t_masks;
		rd(12'h0AC, 16'h8000);
		wr(12'h0AA, 16'hFFFF);
		rd(12'h0AA, 16'h7F7F);
		wr(12'h0AE, 16'hFFFF);
		rd(12'h0AE, 16'h073F);
		wr(12'h0BC, 16'hFFFF);
		rd(12'h0BC, 16'h0000);
		settle;
		chk(EGRESS_CFG.prio3_rate, 7'h00);
		chk({GLOBAL_CFG.invalid_vid_mask, GLOBAL_CFG.pvid_insert}, 9'h1FF);
		wr(12'h0A8, 16'h0080);
		settle;
		chk({EGRESS_CFG.prio3_rate, EGRESS_CFG.prio2_rate}, 14'h3FFF);
		chk({EGRESS_CFG.egress_en, EGRESS_CFG.prio1_rate, EGRESS_CFG.prio0_rate}, 15'h4000);
		wr(12'h0AA, 16'h0000, 2'h1);
		settle;
		chk({EGRESS_CFG.prio3_rate, EGRESS_CFG.prio2_rate}, 14'h3F80);
		$display("masks and egress done");
	endtask : t_masks
	task t_src;
		for (int i = 0; i < 6; i++) wr(12'h0B0 + 12'(2 * i), 16'(16'h1111 * (i + 1)));
		settle;
		chk(SRC_FILTER1, 48'h333322221111);
		chk(SRC_FILTER2, 48'h666655554444);
		$display("source filters done");
	endtask : t_src
	task t_flush;
		wr(12'h0AC, 16'h03FF);
		settle;
		chk({GLOBAL_CFG.static_flush_en, GLOBAL_CFG.tail_tag_en, GLOBAL_CFG.pause_limit}, 10'h3FF);
		chk({GLOBAL_CFG.two_queue_map, GLOBAL_CFG.pause_limit_en}, 3'h1);
		// Port learning is taken as already off before this flush
		wr(12'h0AC, 16'h0400);
		wt(1'b1);
		wt(1'b0);
		rd(12'h0AC, 16'h0000);
		chk(GLOBAL_CFG.pause_limit_en, 1'b0);
		$display("flush done");
	endtask : t_flush
	initial begin
		repeat (20) @(posedge CLK);
		RST_B <= 1'b1;
		repeat (3) @(posedge CLK);
		t_masks;
		t_src;
		t_flush;
		results();
	end
endmodule : sw_global_regs_tb
`default_nettype wire
